// file: common/fault_resp_pkg.sv
// Constants and state type of the current fault response.
// Function
// - Restart codes 100 to 110 give four to six tries.
// - Restart tries are one delay interval apart.
// - Code 111 retries until turned off or stopped.
// - The delay field gives two to its value in external time units.
// - The low-voltage threshold lives at 0x48.
// - The linear warning threshold lives at 0x4A.
// - Current is compared with the threshold at 0x4B.
// - The reaction at 0x4C sets the under-current response.
// - Every reaction pulls the alert low and sets status.
// - Reaction 00 keeps the output running.
// - Reaction 01 runs for the delay, then restarts.
// - Reaction 10 disables at once, then restarts.
// - Reaction 11 stays off only while the fault lasts.
// - Restart code 000 latches the output off.
// - Restart codes 001 to 011 give one to three tries.
package fault_resp_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0]  CMD_OC_LV_THRESH = 8'h48;
    localparam logic [7:0]  CMD_OC_WARN      = 8'h4A;
    localparam logic [7:0]  CMD_UC_THRESH    = 8'h4B;
    localparam logic [7:0]  CMD_UC_REACT     = 8'h4C;

    // ****************************************
    // Reaction register fields
    // ****************************************
    localparam int          RESP_HI  = 7;
    localparam int          RESP_LO  = 6;
    localparam int          RETRY_HI = 5;
    localparam int          RETRY_LO = 3;
    localparam int          DELAY_HI = 2;
    localparam int          DELAY_LO = 0;
    localparam logic [1:0]  RESP_IGNORE   = 2'h0;
    localparam logic [1:0]  RESP_RIDE     = 2'h1;
    localparam logic [1:0]  RESP_SHUT     = 2'h2;
    localparam logic [1:0]  RESP_HOLD     = 2'h3;
    localparam logic [2:0]  RETRY_FOREVER = 3'h7;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] RST_OC_LV     = 16'h0000;
    localparam logic [15:0] RST_OC_WARN   = 16'h0000;
    localparam logic [15:0] RST_UC_THRESH = 16'h0000;
    localparam logic [7:0]  RST_UC_REACT  = 8'h00;

    // ****************************************
    // Linear format and timing widths
    // ****************************************
    localparam int          LIN_EXP_HI  = 15;
    localparam int          LIN_EXP_LO  = 11;
    localparam int          LIN_MANT_W  = 11;
    localparam int          FIX_W       = 48;
    localparam int          UNIT_W      = 24;
    localparam int          UNIT_CNT_W  = 8;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_RUN   = 3'b001,
        ST_RIDE  = 3'b010,
        ST_WAIT  = 3'b011,
        ST_PROBE = 3'b100,
        ST_HOLD  = 3'b101,
        ST_LATCH = 3'b110
    } state_t;

endpackage

// file: core/fault_delay_timer.sv
// Delay timer counting a number of time units of a given length in cycles.
`timescale 1ns/1ps
`default_nettype none
module fault_delay_timer
    import fault_resp_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  start,
    input  wire logic [UNIT_W-1:0]     unit_cycles,
    input  wire logic [UNIT_CNT_W-1:0] unit_count,
    output var  logic                  done
);

    logic [UNIT_W-1:0]     div_cnt;
    logic [UNIT_CNT_W-1:0] units_left;
    logic                  busy;
    logic                  unit_tick;

    // A unit length of zero is treated as one cycle.
    assign unit_tick = busy && ((div_cnt + 1'b1 >= unit_cycles) ||
                                (unit_cycles == '0));

    // ****************************************
    // Divider and unit counter
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt    <= '0;
            units_left <= '0;
            busy       <= 1'b0;
            done       <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                div_cnt    <= '0;
                units_left <= unit_count;
                busy       <= 1'b1;
            end else if (unit_tick) begin
                div_cnt <= '0;
                if (units_left <= 8'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    units_left <= units_left - 1'b1;
                end
            end else if (busy) begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

endmodule // fault_delay_timer
`default_nettype wire

// file: core/current_fault_response_ctrl.sv
// Under-current fault response, current thresholds and command registers.
`timescale 1ns/1ps
`default_nettype none
module current_fault_response_ctrl
    import fault_resp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [7:0]        cmd_code,
    input  wire logic [15:0]       cmd_wdata,
    output var  logic              cmd_ack,
    output var  logic              cmd_unknown,
    output var  logic [15:0]       cmd_rdata,
    input  wire logic              iout_valid,
    input  wire logic [15:0]       iout_meas,
    input  wire logic              remote_on_pin,
    input  wire logic              operation_on,
    input  wire logic              bias_power_good,
    input  wire logic              other_fault_off,
    input  wire logic              clear_faults,
    input  wire logic [UNIT_W-1:0] run_unit_cycles,
    input  wire logic [UNIT_W-1:0] retry_unit_cycles,
    output var  logic              output_enable,
    output var  logic              alert_line_n,
    output var  logic              uc_fault_status,
    output var  logic              oc_warn_status,
    output var  logic [15:0]       oc_lv_threshold
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [15:0]           oc_warn_threshold;
    logic [15:0]           uc_fault_threshold;
    logic [7:0]            uc_fault_reaction;
    logic                  remote_meta;
    logic                  remote_sync;
    logic                  bias_meta;
    logic                  bias_sync;
    logic                  on_prev;
    logic                  on_req;
    logic                  on_rise;
    logic                  on_fall;
    logic                  uc_below;
    logic                  warn_above;
    logic                  uc_hit;
    logic                  uc_gone;
    logic                  warn_hit;
    logic                  next_uc_status;
    logic                  next_warn_status;
    logic                  uc_present;
    state_t                state;
    logic [2:0]            attempts;
    logic                  retry_left;
    logic                  timer_start;
    logic                  timer_retry;
    logic                  timer_done;
    logic [UNIT_W-1:0]     timer_unit;
    logic [UNIT_CNT_W-1:0] timer_count;
    logic [1:0]            resp_code;
    logic [2:0]            retry_code;
    logic [2:0]            delay_code;

    // ****************************************
    // Linear format conversion
    // ****************************************
    // Mantissa times two to the exponent, scaled by two to the sixteenth.
    function automatic logic signed [FIX_W-1:0] lin_to_fix(
        input logic [15:0] v
    );
        logic signed [FIX_W-1:0] mant;
        logic [4:0]              shift;
        mant  = {{(FIX_W-LIN_MANT_W){v[LIN_MANT_W-1]}}, v[LIN_MANT_W-1:0]};
        shift = {~v[LIN_EXP_HI], v[LIN_EXP_HI-1:LIN_EXP_LO]};
        return mant <<< shift;
    endfunction

    assign resp_code  = uc_fault_reaction[RESP_HI:RESP_LO];
    assign retry_code = uc_fault_reaction[RETRY_HI:RETRY_LO];
    assign delay_code = uc_fault_reaction[DELAY_HI:DELAY_LO];

    assign uc_below   = lin_to_fix(iout_meas) <
                        lin_to_fix(uc_fault_threshold);
    assign warn_above = lin_to_fix(iout_meas) >
                        lin_to_fix(oc_warn_threshold);
    assign uc_hit     = iout_valid && uc_below;
    assign uc_gone    = iout_valid && !uc_below;
    assign warn_hit   = iout_valid && warn_above;

    // ****************************************
    // Command registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_lv_threshold    <= RST_OC_LV;
            oc_warn_threshold  <= RST_OC_WARN;
            uc_fault_threshold <= RST_UC_THRESH;
            uc_fault_reaction  <= RST_UC_REACT;
            cmd_ack            <= 1'b0;
            cmd_unknown        <= 1'b0;
            cmd_rdata          <= 16'h0000;
        end else begin
            cmd_ack     <= cmd_valid;
            cmd_unknown <= 1'b0;
            if (cmd_valid) begin
                if (cmd_code == CMD_OC_LV_THRESH) begin
                    cmd_rdata <= oc_lv_threshold;
                    if (cmd_write) begin
                        oc_lv_threshold <= cmd_wdata;
                    end
                end else if (cmd_code == CMD_OC_WARN) begin
                    cmd_rdata <= oc_warn_threshold;
                    if (cmd_write) begin
                        oc_warn_threshold <= cmd_wdata;
                    end
                end else if (cmd_code == CMD_UC_THRESH) begin
                    cmd_rdata <= uc_fault_threshold;
                    if (cmd_write) begin
                        uc_fault_threshold <= cmd_wdata;
                    end
                end else if (cmd_code == CMD_UC_REACT) begin
                    cmd_rdata <= {8'h00, uc_fault_reaction};
                    if (cmd_write) begin
                        uc_fault_reaction <= cmd_wdata[7:0];
                    end
                end else begin
                    cmd_rdata   <= 16'h0000;
                    cmd_unknown <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Pin synchronisers and on request
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            remote_meta <= 1'b0;
            remote_sync <= 1'b0;
            bias_meta   <= 1'b0;
            bias_sync   <= 1'b0;
        end else begin
            remote_meta <= remote_on_pin;
            remote_sync <= remote_meta;
            bias_meta   <= bias_power_good;
            bias_sync   <= bias_meta;
        end
    end

    assign on_req  = remote_sync && operation_on;
    assign on_rise = on_req && !on_prev;
    assign on_fall = !on_req && on_prev;

    // Losing bias forgets the last on level, so the next on is an edge.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            on_prev <= 1'b0;
        end else if (!bias_sync) begin
            on_prev <= 1'b0;
        end else begin
            on_prev <= on_req;
        end
    end

    // ****************************************
    // Fault level and status
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            uc_present <= 1'b0;
        end else if (iout_valid) begin
            uc_present <= uc_below;
        end
    end

    // A new event wins over a clear in the same cycle.
    assign next_uc_status   = uc_hit || (uc_fault_status && !clear_faults);
    assign next_warn_status = warn_hit || (oc_warn_status && !clear_faults);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            uc_fault_status <= 1'b0;
            oc_warn_status  <= 1'b0;
        end else begin
            uc_fault_status <= next_uc_status;
            oc_warn_status  <= next_warn_status;
        end
    end

    // ****************************************
    // Alert and output enable
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alert_line_n <= 1'b1;
        end else begin
            alert_line_n <= !(next_uc_status || next_warn_status);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= (state == ST_RUN) || (state == ST_RIDE) ||
                             (state == ST_PROBE);
        end
    end

    // ****************************************
    // Restart budget
    // ****************************************
    assign retry_left = (retry_code == RETRY_FOREVER) ||
                        (attempts < retry_code);

    // ****************************************
    // Delay timer
    // ****************************************
    assign timer_unit  = timer_retry ? retry_unit_cycles : run_unit_cycles;
    assign timer_count = UNIT_CNT_W'(8'h01 << delay_code);

    fault_delay_timer u_delay (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .start       (timer_start),
        .unit_cycles (timer_unit),
        .unit_count  (timer_count),
        .done        (timer_done)
    );

    // ****************************************
    // Response state machine
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state       <= ST_OFF;
            attempts    <= 3'h0;
            timer_start <= 1'b0;
            timer_retry <= 1'b0;
        end else begin
            timer_start <= 1'b0;
            if (!bias_sync || on_fall || other_fault_off) begin
                state    <= ST_OFF;
                attempts <= 3'h0;
            end else begin
                case (state)
                    ST_OFF: begin
                        if (on_rise) begin
                            state <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (uc_hit) begin
                            case (resp_code)
                                RESP_RIDE: begin
                                    state       <= ST_RIDE;
                                    timer_start <= 1'b1;
                                    timer_retry <= 1'b0;
                                end
                                RESP_SHUT: begin
                                    if (retry_left) begin
                                        state       <= ST_WAIT;
                                        timer_start <= 1'b1;
                                        timer_retry <= 1'b1;
                                    end else begin
                                        state <= ST_LATCH;
                                    end
                                end
                                RESP_HOLD: begin
                                    state <= ST_HOLD;
                                end
                                default: begin
                                    state <= ST_RUN;
                                end
                            endcase
                        end
                    end
                    ST_RIDE: begin
                        if (uc_gone) begin
                            state <= ST_RUN;
                        end else if (timer_done && uc_present) begin
                            if (retry_left) begin
                                state       <= ST_WAIT;
                                timer_start <= 1'b1;
                                timer_retry <= 1'b1;
                            end else begin
                                state <= ST_LATCH;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (timer_done) begin
                            state       <= ST_PROBE;
                            timer_start <= 1'b1;
                            timer_retry <= 1'b1;
                            if (retry_code != RETRY_FOREVER) begin
                                attempts <= attempts + 1'b1;
                            end
                        end
                    end
                    ST_PROBE: begin
                        if (uc_hit) begin
                            if (retry_left) begin
                                state       <= ST_WAIT;
                                timer_start <= 1'b1;
                                timer_retry <= 1'b1;
                            end else begin
                                state <= ST_LATCH;
                            end
                        end else if (timer_done) begin
                            state    <= ST_RUN;
                            attempts <= 3'h0;
                        end
                    end
                    ST_HOLD: begin
                        if (uc_gone) begin
                            state <= ST_RUN;
                        end
                    end
                    ST_LATCH: begin
                        state <= ST_LATCH;
                    end
                    default: begin
                        state <= ST_OFF;
                    end
                endcase
            end
        end
    end

endmodule // current_fault_response_ctrl
`default_nettype wire

// file: tb/cfr_asserts.sv
// Concurrent checks on the ports of the current fault response block.
`timescale 1ns/1ps
`default_nettype none
module cfr_asserts
    import fault_resp_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic        cmd_ack,
    input wire logic        cmd_unknown,
    input wire logic [15:0] cmd_rdata,
    input wire logic        iout_valid,
    input wire logic        bias_power_good,
    input wire logic        other_fault_off,
    input wire logic        clear_faults,
    input wire logic        output_enable,
    input wire logic        alert_line_n,
    input wire logic        uc_fault_status,
    input wire logic        oc_warn_status,
    input wire logic [15:0] oc_lv_threshold
);
    // ****
    // Assertions
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic known;
    logic lv_wr;
    assign known = cmd_code inside {CMD_OC_LV_THRESH, CMD_OC_WARN,
                                    CMD_UC_THRESH, CMD_UC_REACT};
    assign lv_wr = cmd_valid && cmd_write && cmd_code == CMD_OC_LV_THRESH;
    AST_ACK: assert property (cmd_valid |=> cmd_ack)
        else $error("no acknowledge");
    AST_ACK_SRC: assert property (cmd_ack |-> $past(cmd_valid))
        else $error("stray acknowledge");
    AST_UNKNOWN: assert property (cmd_valid && !known |=>
        cmd_unknown && cmd_rdata == 16'h0000)
        else $error("unknown code not refused");
    AST_LV_WR: assert property (lv_wr |=>
        oc_lv_threshold == $past(cmd_wdata))
        else $error("threshold not written");
    AST_LV_HOLD: assert property (!lv_wr |=> $stable(oc_lv_threshold))
        else $error("threshold changed");
    AST_UC_CAUSE: assert property ($rose(uc_fault_status) |->
        $past(iout_valid))
        else $error("status set without measurement");
    AST_ALERT: assert property (uc_fault_status || oc_warn_status |->
        !alert_line_n)
        else $error("alert high with status set");
    AST_ALERT_SRC: assert property (!alert_line_n |->
        uc_fault_status || oc_warn_status)
        else $error("alert low without status");
    AST_STICKY: assert property (uc_fault_status && !clear_faults |=>
        uc_fault_status)
        else $error("status lost");
    AST_OTHER: assert property (other_fault_off |->
        ##[1:2] !output_enable)
        else $error("output on after fault");
    AST_BIAS: assert property ((!bias_power_good) [*5] |->
        !output_enable)
        else $error("output on without bias");
endmodule // cfr_asserts
bind current_fault_response_ctrl cfr_asserts cfr_asserts_inst (.*);
`default_nettype wire

// file: tb/pmbus_host_model.sv
// Host model issuing commands on the block's command port.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
    input  wire logic        clk,
    output var  logic        cmd_valid,
    output var  logic        cmd_write,
    output var  logic [7:0]  cmd_code,
    output var  logic [15:0] cmd_wdata,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_unknown,
    input  wire logic [15:0] cmd_rdata
);
    // ****
    // Command transfer
    // ****
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // Released lines show the inverse of the last value.
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d, output logic [15:0] rd,
                        output logic uk, output logic ak);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_write = ~w;
        cmd_code  = ~c;
        cmd_wdata = ~d;
        rd = cmd_rdata;
        uk = cmd_unknown;
        ak = cmd_ack;
    endtask
endmodule // pmbus_host_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the current fault response block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fault_resp_pkg::*;
    // ****
    // Bench
    // ****
    localparam logic [15:0]       LOW  = 16'h0004;
    localparam logic [15:0]       MID  = 16'h0020;
    localparam logic [15:0]       HIGH = 16'h0050;
    localparam logic [15:0]       UCT  = 16'h0010;
    localparam logic [15:0]       WRN  = 16'h0040;
    localparam logic [UNIT_W-1:0] UNIT = 24'h000004;
    logic        clk = 1'b0, sys_rst = 1'b1, iout_valid = 1'b0;
    logic        remote_on_pin = 1'b1, operation_on = 1'b1;
    logic        bias_power_good = 1'b1, other_fault_off = 1'b0;
    logic        clear_faults = 1'b0, cmd_valid, cmd_write, cmd_ack;
    logic        cmd_unknown, output_enable, alert_line_n;
    logic        uc_fault_status, oc_warn_status;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, oc_lv_threshold;
    logic [15:0] iout_meas = 16'h0000, react = 16'h0000;
    logic [7:0]  cd [4] = '{8'h48, 8'h4A, 8'h4B, 8'h4C};
    logic [15:0] wv [4] = '{16'h1234, WRN, UCT, 16'hFF00};
    logic [15:0] ev [4] = '{16'h1234, WRN, UCT, 16'h0000};
    int          miscompares = 0, cmp_count = 0, cyc = 0, rises = 0;
    int          gap = 0, last_rise = 0, base, seen, k;
    initial forever #4 clk = ~clk;
    pmbus_host_model host_inst (.*);
    current_fault_response_ctrl current_fault_response_ctrl_inst (.*,
        .run_unit_cycles(UNIT), .retry_unit_cycles(UNIT));
    always @(posedge output_enable) begin
        rises = rises + 1;
        gap = cyc - last_rise;
        last_rise = cyc;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares = miscompares + 1;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] c,
                       input logic [15:0] d, input logic [15:0] e,
                       input logic u);
        logic [15:0] rd;
        logic        uk, ak;
        host_inst.xfer(w, c, d, rd, uk, ak);
        chk1("cmd_ack", 1'b1, ak);
        chk1("cmd_unknown", u, uk);
        chk("cmd_rdata", e, rd);
    endtask
    task automatic setr(input logic [7:0] v);
        acc(1'b1, CMD_UC_REACT, {8'h00, v}, react, 1'b0);
        react = {8'h00, v};
    endtask
    task automatic meas(input logic [15:0] v);
        @(negedge clk);
        iout_valid = 1'b1;
        iout_meas = v;
        @(negedge clk);
        iout_valid = 1'b0;
        iout_meas = ~v;
    endtask
    task automatic wait_oe(input logic e, input int n);
        int i;
        i = 0;
        while (output_enable !== e && i < n) begin
            @(negedge clk);
            i++;
        end
        chk1("output_enable", e, output_enable);
    endtask
    task automatic hold_oe(input logic e, input int n);
        int d;
        d = 0;
        repeat (n) begin
            @(negedge clk);
            if (output_enable !== e) d++;
        end
        chk("output_enable wrong cycles", 16'h0000, 16'(d));
    endtask
    task automatic pulse_clear();
        @(negedge clk);
        clear_faults = 1'b1;
        @(negedge clk);
        clear_faults = 1'b0;
    endtask
    task automatic cycle_on();
        @(negedge clk);
        remote_on_pin = 1'b0;
        repeat (6) @(negedge clk);
        remote_on_pin = 1'b1;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 4; i++) acc(1'b0, cd[i], 16'h0000, 16'h0000, 1'b0);
        for (int i = 0; i < 4; i++) acc(1'b1, cd[i], wv[i], 16'h0000, 1'b0);
        for (int i = 0; i < 4; i++) acc(1'b0, cd[i], 16'h0000, ev[i], 1'b0);
        acc(1'b1, 8'h4D, 16'h5555, 16'h0000, 1'b1);
        acc(1'b0, CMD_UC_THRESH, 16'h0000, UCT, 1'b0);
        chk("oc_lv_threshold", 16'h1234, oc_lv_threshold);
        $display("test registers done");
        wait_oe(1'b1, 30);
        meas(UCT);
        chk1("uc_fault_status", 1'b0, uc_fault_status);
        meas(HIGH);
        chk1("oc_warn_status", 1'b1, oc_warn_status);
        chk1("alert_line_n", 1'b0, alert_line_n);
        pulse_clear();
        chk1("alert_line_n", 1'b1, alert_line_n);
        meas(LOW);
        chk1("uc_fault_status", 1'b1, uc_fault_status);
        chk1("alert_line_n", 1'b0, alert_line_n);
        hold_oe(1'b1, 40);
        pulse_clear();
        chk1("uc_fault_status", 1'b0, uc_fault_status);
        $display("test ignore done");
        setr(8'h42);
        meas(LOW);
        hold_oe(1'b1, 10);
        wait_oe(1'b0, 40);
        meas(MID);
        hold_oe(1'b0, 20);
        cycle_on();
        wait_oe(1'b1, 20);
        meas(LOW);
        repeat (3) @(negedge clk);
        meas(MID);
        hold_oe(1'b1, 40);
        $display("test ride done");
        setr(8'hC0);
        meas(LOW);
        wait_oe(1'b0, 10);
        hold_oe(1'b0, 20);
        meas(MID);
        wait_oe(1'b1, 10);
        $display("test hold done");
        for (int r = 0; r < 8; r++) begin
            setr({2'b10, 3'(r), 3'b001});
            cycle_on();
            wait_oe(1'b1, 20);
            base = rises;
            seen = rises;
            meas(LOW);
            k = 0;
            while (k < 800 && (r < 7 || rises - base < 8)) begin
                @(negedge clk);
                k++;
                if (rises != seen) begin
                    seen = rises;
                    meas(LOW);
                end
            end
            chk("attempts", (r == 7) ? 16'h0008 : 16'(r), 16'(rises - base));
            if (r == 2)
                chk1("restart gap", 1'b1, gap >= 8 && gap <= 18);
            if (r < 7) begin
                meas(MID);
                hold_oe(1'b0, 20);
            end else begin
                other_fault_off = 1'b1;
                @(negedge clk);
                other_fault_off = 1'b0;
                hold_oe(1'b0, 40);
            end
        end
        $display("test restart done");
        bias_power_good = 1'b0;
        hold_oe(1'b0, 8);
        bias_power_good = 1'b1;
        operation_on = 1'b0;
        repeat (6) @(negedge clk);
        operation_on = 1'b1;
        wait_oe(1'b1, 20);
        $display("test bias done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
